// ==== include/rtc_pkg.sv ====
// =====================================================================
// Shared constants for the reference and temperature control block
package rtc_pkg;

  // =====================================================================
  // Register map
  localparam logic [11:0] RTC_CTRL_ADDR   = 12'h20C;
  localparam logic [7:0]  RTC_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  RTC_CTRL_WMASK  = 8'hBF;  // Ready bit is read-only

  // =====================================================================
  // Field positions in the control register
  localparam int CTRL_EN_BIT    = 7;
  localparam int CTRL_RDY_BIT   = 6;
  localparam int CTRL_TEMP_SENSE_ENABLE_BIT  = 5;
  localparam int CTRL_TEMP_RANGE_SELECT_BIT = 4;
  localparam int CTRL_B2_LSB    = 2;
  localparam int CTRL_B1_LSB    = 0;

  // =====================================================================
  // Buffer gain codes
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_1X  = 2'h1;
  localparam logic [1:0] GAIN_2X  = 2'h2;
  localparam logic [1:0] GAIN_4X  = 2'h3;

  // =====================================================================
  // Settling time of the reference and buffers
  localparam int          CLK_PERIOD_NS  = 25;
  localparam int          SETTLE_TIME_NS = 2000;
  localparam int          SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SETTLE_LAST    = 8'(SETTLE_CYCLES - 1);

  // =====================================================================
  // Settling state machine
  typedef enum logic [2:0]
  {
    RTC_ST_IDLE   = 3'h1,
    RTC_ST_SETTLE = 3'h2,
    RTC_ST_READY  = 3'h4
  } rtc_settle_state_type;

endpackage

// ==== include/rtc_ctrl_if.sv ====
`timescale 1ns/1ps
// =====================================================================
// Link between the register file and the settling timer
interface rtc_ctrl_if;
  logic ref_en_next;  // Enable value taking effect at the coming edge
  logic ref_rise;     // Enable goes from zero to one at the coming edge
  logic ready;        // Registered ready flag

  modport ctrl
  (
    output ref_en_next,
    output ref_rise,
    input  ready
  );

  modport timer
  (
    input  ref_en_next,
    input  ref_rise,
    output ready
  );
endinterface

// ==== rtl/rtc_settle.sv ====
`timescale 1ns/1ps
// =====================================================================
// Settling timer: raises ready a fixed count after the reference is on
module rtc_settle
  import rtc_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_sys_i,
  input  wire logic      sys_rst_i,
  // Control link
  rtc_ctrl_if.timer      ctl
);

  localparam int SETTLE_WAIT = SETTLE_CYCLES;

  rtc_settle_state_type state_reg;
  rtc_settle_state_type state_next;
  logic [7:0]           cnt_reg;
  logic [7:0]           cnt_next;
  logic                 ready_reg;
  logic                 ready_next;

  // =====================================================================
  // Next state; the enable is looked at one cycle early so ready drops
  // in the same cycle as the enable bit
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (!ctl.ref_en_next)
    begin
      state_next = RTC_ST_IDLE;
      cnt_next   = 8'h00;
    end
    else if (ctl.ref_rise)
    begin
      state_next = RTC_ST_SETTLE;
      cnt_next   = 8'h00;
    end
    else
    begin
      case (state_reg)
        RTC_ST_SETTLE:
        begin
          if (cnt_reg == SETTLE_LAST)
            state_next = RTC_ST_READY;
          else
            cnt_next = cnt_reg + 8'h01;
        end
        RTC_ST_READY:  state_next = RTC_ST_READY;
        RTC_ST_IDLE:   state_next = RTC_ST_IDLE;
        default:       state_next = RTC_ST_IDLE;
      endcase
    end
    ready_next = (state_next == RTC_ST_READY);
  end

  // Registers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= RTC_ST_IDLE;
      cnt_reg   <= 8'h00;
      ready_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  assign ctl.ready = ready_reg;

  // =====================================================================
  // Checks
  a_ready_after_count: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(ready_reg) |-> $past(ctl.ref_rise, SETTLE_WAIT + 1))
    else $error("ready rose without a full settling count");

  a_ready_drops_now: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (!ctl.ref_en_next || ctl.ref_rise) |=> !ready_reg)
    else $error("ready not cleared on disable or restart");

endmodule

// ==== rtl/rtc_buffer_gain.sv ====
`timescale 1ns/1ps
// =====================================================================
// Gain decoder for one reference buffer
module rtc_buffer_gain
  import rtc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // Control values taking effect at the coming edge
  input  wire logic       ref_en_next_i,
  input  wire logic [1:0] gain_code_next_i,
  // Buffer drive: one-hot 1x, 2x, 4x
  output logic      [2:0] gain_o,
  output logic            on_o
);

  logic [2:0] gain_reg;
  logic [2:0] gain_next;
  logic       on_reg;
  logic       on_next;

  // Code to one-hot gain
  function automatic logic [2:0] rtc_gain_onehot(input logic [1:0] code);
    case (code)
      GAIN_1X: rtc_gain_onehot = 3'h1;
      GAIN_2X: rtc_gain_onehot = 3'h2;
      GAIN_4X: rtc_gain_onehot = 3'h4;
      default: rtc_gain_onehot = 3'h0;
    endcase
  endfunction

  // =====================================================================
  // A buffer has nothing to amplify while the reference is off
  always_comb
  begin
    on_next   = ref_en_next_i && (gain_code_next_i != GAIN_OFF);
    gain_next = on_next ? rtc_gain_onehot(gain_code_next_i) : 3'h0;
  end

  // Registers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      gain_reg <= 3'h0;
      on_reg   <= 1'b0;
    end
    else
    begin
      gain_reg <= gain_next;
      on_reg   <= on_next;
    end
  end

  assign gain_o = gain_reg;
  assign on_o   = on_reg;

  // =====================================================================
  // Checks
  a_gain_code_off: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (gain_code_next_i == GAIN_OFF) |=> (!on_reg && gain_reg == 3'h0))
    else $error("buffer on with the off code");

endmodule

// ==== rtl/rtc_top.sv ====
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Control bit 7 switches the fixed reference on when one and off when zero.
// - Control bit 6 is a read-only ready flag, one only while the reference is usable.
// - After enabling, ready stays low until the circuits have settled, then hardware sets it.
// - Control bit 5 switches the die temperature sensor on when one and off when zero.
// - Control bit 4 picks the sensor range: one for three junction drops, zero for two.
// - Bits 3:2 set the second buffer gain: 11 is 4x, 10 is 2x, 01 is 1x, 00 is off.
// - Bits 1:0 set the first buffer gain with the same coding.
// - The second buffer feeds DAC and comparator, and the converter only as an input channel.
// - The first buffer is offered to the converter as positive reference and as a channel.
// - Reference and sensor controls share one 8-bit register at offset 0x020C.
// - The converter has a dedicated input channel for the sensor voltage.
module rtc_top
  import rtc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Reference and sensor controls
  output logic             fixed_reference_enable_o,
  output logic             fixed_reference_ready_o,
  output logic             temp_sense_enable_o,
  output logic             temp_range_select_o,
  // Buffer drive
  output logic      [2:0]  buffer1_gain_o,
  output logic             buffer1_adc_ref_o,
  output logic      [2:0]  buffer2_gain_o,
  output logic             buffer2_dac_cmp_o,
  // Converter channel availability: bit 0 buffer 1, bit 1 buffer 2, bit 2 sensor
  output logic      [2:0]  adc_channel_avail_o
);

  // =====================================================================
  // Declarations
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic [2:0]  chan_reg;
  logic [2:0]  chan_next;
  logic        apb_setup;
  logic        apb_write;
  logic [7:0]  ctrl_readback;
  logic [2:0]  gain_w [2];
  logic        on_w   [2];

  rtc_ctrl_if ctl_if ();

  // Address decode, shared by read, write and error paths
  function automatic logic rtc_addr_hit(input logic [11:0] addr);
    rtc_addr_hit = (addr == RTC_CTRL_ADDR);
  endfunction

  // =====================================================================
  // APB phase detection
  assign apb_setup = psel_i && !penable_i;
  // Write lands only at the completing access edge, on byte lane 0
  assign apb_write = psel_i && penable_i && pready_reg && pwrite_i
                     && rtc_addr_hit(paddr_i) && pstrb_i[0];

  // Read view: ready comes from the timer, not from the stored bit
  always_comb
  begin
    ctrl_readback               = ctrl_reg;
    ctrl_readback[CTRL_RDY_BIT] = ctl_if.ready;
  end

  // =====================================================================
  // Bus answer: every transfer completes with no wait state, so pready
  // is registered from the setup cycle and stands for the access cycle
  always_comb
  begin
    pready_next  = apb_setup;
    pslverr_next = apb_setup && !rtc_addr_hit(paddr_i);
    prdata_next  = prdata_reg;
    if (apb_setup)
    begin
      if (!pwrite_i && rtc_addr_hit(paddr_i))
        prdata_next = {24'h000000, ctrl_readback};
      else
        prdata_next = 32'h00000000;
    end
  end

  // Bus registers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end
    else
    begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  // =====================================================================
  // Control register; the ready position is never stored
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (apb_write)
      ctrl_next = pwdata_i[7:0] & RTC_CTRL_WMASK;
  end

  // Converter channels follow the sources that feed them
  always_comb
  begin
    chan_next    = 3'h0;
    chan_next[0] = ctrl_next[CTRL_EN_BIT] && (ctrl_next[CTRL_B1_LSB +: 2] != GAIN_OFF);
    chan_next[1] = ctrl_next[CTRL_EN_BIT] && (ctrl_next[CTRL_B2_LSB +: 2] != GAIN_OFF);
    chan_next[2] = ctrl_next[CTRL_TEMP_SENSE_ENABLE_BIT];
  end

  // Control registers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_reg <= RTC_CTRL_RESET;
      chan_reg <= 3'h0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      chan_reg <= chan_next;
    end
  end

  // =====================================================================
  // Settling timer, fed one cycle early so ready tracks the enable bit
  assign ctl_if.ref_en_next = ctrl_next[CTRL_EN_BIT];
  assign ctl_if.ref_rise    = ctrl_next[CTRL_EN_BIT] && !ctrl_reg[CTRL_EN_BIT];

  rtc_settle u_settle
  (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .ctl       (ctl_if.timer)
  );

  // =====================================================================
  // Two identical buffer decoders, buffer 1 at index 0
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_buf
      rtc_buffer_gain u_gain
      (
        .clk_sys_i        (clk_sys_i),
        .sys_rst_i        (sys_rst_i),
        .ref_en_next_i    (ctrl_next[CTRL_EN_BIT]),
        .gain_code_next_i (ctrl_next[2*i +: 2]),
        .gain_o           (gain_w[i]),
        .on_o             (on_w[i])
      );
    end
  endgenerate

  // =====================================================================
  // Outputs, all taken straight from flip-flops
  assign prdata_o                 = prdata_reg;
  assign pready_o                 = pready_reg;
  assign pslverr_o                = pslverr_reg;
  assign fixed_reference_enable_o = ctrl_reg[CTRL_EN_BIT];
  assign fixed_reference_ready_o  = ctl_if.ready;
  assign temp_sense_enable_o      = ctrl_reg[CTRL_TEMP_SENSE_ENABLE_BIT];
  assign temp_range_select_o      = ctrl_reg[CTRL_TEMP_RANGE_SELECT_BIT];
  assign buffer1_gain_o           = gain_w[0];
  // first buffer is the only converter reference
  assign buffer1_adc_ref_o        = on_w[0];
  assign buffer2_gain_o           = gain_w[1];
  assign buffer2_dac_cmp_o        = on_w[1];
  assign adc_channel_avail_o      = chan_reg;

  // =====================================================================
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_ctrl_write;
    psel_i && penable_i && pready_reg && pwrite_i && paddr_i == RTC_CTRL_ADDR && pstrb_i[0];
  endsequence

  sequence s_setup_read;
    psel_i && !penable_i && !pwrite_i && paddr_i == RTC_CTRL_ADDR;
  endsequence

  a_ref_enable_write: assert property (
    s_ctrl_write |=> fixed_reference_enable_o == $past(pwdata_i[7]))
    else $error("reference enable did not follow the write");

  a_ready_needs_en: assert property (
    fixed_reference_ready_o |-> fixed_reference_enable_o)
    else $error("ready set while the reference is off");

  a_ready_readback: assert property (
    s_setup_read |=> prdata_o[CTRL_RDY_BIT] == $past(ctl_if.ready) && pready_o)
    else $error("ready bit read back wrong");

  a_ready_low_start: assert property (
    ($rose(fixed_reference_enable_o)) |-> !fixed_reference_ready_o ##1 !fixed_reference_ready_o)
    else $error("ready high right after enabling");

  a_sensor_fields: assert property (
    s_ctrl_write |=> temp_sense_enable_o == $past(pwdata_i[5]))
    else $error("sensor enable did not follow the write");

  a_range_select: assert property (
    s_ctrl_write |=> temp_range_select_o == $past(pwdata_i[4]))
    else $error("range select did not follow the write");

  a_buf2_gain_4x: assert property (
    (s_ctrl_write ##0 pwdata_i[7] && pwdata_i[3:2] == GAIN_4X) |=> buffer2_gain_o == 3'h4)
    else $error("second buffer not at 4x");

  a_buf1_gain_2x: assert property (
    (s_ctrl_write ##0 pwdata_i[7] && pwdata_i[1:0] == GAIN_2X) |=> buffer1_gain_o == 3'h2)
    else $error("first buffer not at 2x");

  a_buf2_route: assert property (
    buffer2_dac_cmp_o == adc_channel_avail_o[1])
    else $error("second buffer routing mismatch");

  a_buf1_route: assert property (
    buffer1_adc_ref_o == adc_channel_avail_o[0])
    else $error("first buffer routing mismatch");

  a_ctrl_unmapped: assert property (
    (psel_i && penable_i && pready_reg && paddr_i != RTC_CTRL_ADDR)
    |-> pslverr_o ##1 $stable(ctrl_reg))
    else $error("unmapped access touched the control register");

  a_temp_channel: assert property (
    adc_channel_avail_o[2] == temp_sense_enable_o)
    else $error("sensor channel does not track the sensor enable");

  a_bus_answer: assert property (
    (psel_i && !penable_i) |=> pready_o)
    else $error("no answer in the access cycle");

  a_answer_one_cycle: assert property (
    pready_o |=> !pready_o)
    else $error("pready stood longer than one cycle");

  a_unmapped_read: assert property (
    (psel_i && !penable_i && paddr_i != RTC_CTRL_ADDR)
    |=> (pslverr_o && prdata_o == 32'h00000000))
    else $error("unmapped access not refused");

  a_strobe_ignored: assert property (
    (psel_i && penable_i && pready_reg && pwrite_i && !pstrb_i[0]) |=> $stable(ctrl_reg))
    else $error("write without byte lane 0 changed the register");

  a_ready_not_stored: assert property (
    !ctrl_reg[CTRL_RDY_BIT])
    else $error("ready position stored in the register");

  a_ready_clear_write: assert property (
    (s_ctrl_write ##0 !pwdata_i[7]) |=> !fixed_reference_ready_o)
    else $error("ready not cleared by the disabling write");

  a_ref_off_buffers: assert property (
    !fixed_reference_enable_o |-> (buffer1_gain_o == 3'h0 && buffer2_gain_o == 3'h0))
    else $error("buffer driven while the reference is off");

  a_buf2_gain_1x: assert property (
    (s_ctrl_write ##0 (pwdata_i[7] && pwdata_i[3:2] == GAIN_1X)) |=> buffer2_gain_o == 3'h1)
    else $error("second buffer not at 1x");

  a_buf1_gain_off: assert property (
    (s_ctrl_write ##0 pwdata_i[1:0] == GAIN_OFF)
    |=> (buffer1_gain_o == 3'h0 && !buffer1_adc_ref_o))
    else $error("first buffer not off with the off code");

endmodule

// ==== tb/rtc_analog_model.sv ====
`timescale 1ns/1ps
// =====================================================================
// Analog side: buffer output levels and sensor voltage in millivolts
module rtc_analog_model
#(
  parameter int BASE_MV = 1024,  // Unity-gain reference level
  parameter int DROP_MV = 600    // One junction drop, plain default
)
(
  // Buffer drive from the control block
  input  wire logic [2:0]  buffer1_gain_i,
  input  wire logic [2:0]  buffer2_gain_i,
  input  wire logic        buffer1_adc_ref_i,
  input  wire logic        buffer2_dac_cmp_i,
  // Sensor controls
  input  wire logic        temp_sense_enable_i,
  input  wire logic        temp_range_select_i,
  // Levels seen by the converter, DAC and comparator
  output logic      [15:0] buffer1_mv_o,
  output logic      [15:0] buffer2_mv_o,
  output logic      [15:0] sensor_mv_o
);
  // One-hot gain to level; an illegal pattern reads as a bogus level
  function automatic logic [15:0] level(input logic [2:0] g);
    case (g)
      3'h0:    level = 16'h0;
      3'h1:    level = 16'(BASE_MV);
      3'h2:    level = 16'(2 * BASE_MV);
      3'h4:    level = 16'(4 * BASE_MV);
      default: level = 16'hFFFF;
    endcase
  endfunction

  // Buffers only drive their loads when routed there
  always_comb
  begin
    buffer1_mv_o = buffer1_adc_ref_i ? level(buffer1_gain_i) : 16'h0;
    buffer2_mv_o = buffer2_dac_cmp_i ? level(buffer2_gain_i) : 16'h0;
    sensor_mv_o  = !temp_sense_enable_i ? 16'h0 :
                   temp_range_select_i ? 16'(3 * DROP_MV) : 16'(2 * DROP_MV);
  end
endmodule

// ==== tb/test_reference_temp_control.sv ====
`timescale 1ns/1ps
// =====================================================================
// Register-level bench for the reference and sensor control block
module test_reference_temp_control;
  import rtc_pkg::*;

  logic        clk_sys_i;
  logic        sys_rst_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        en_o;
  logic        rdy_o;
  logic        ts_en_o;
  logic        ts_rng_o;
  logic [2:0]  b1_gain_o;
  logic        b1_ref_o;
  logic [2:0]  b2_gain_o;
  logic        b2_dac_o;
  logic [2:0]  avail_o;
  logic [15:0] b1_mv;
  logic [15:0] b2_mv;
  logic [15:0] ts_mv;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  rtc_top u_rtc_top
  (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .fixed_reference_enable_o(en_o), .fixed_reference_ready_o(rdy_o),
    .temp_sense_enable_o(ts_en_o), .temp_range_select_o(ts_rng_o),
    .buffer1_gain_o(b1_gain_o), .buffer1_adc_ref_o(b1_ref_o), .buffer2_gain_o(b2_gain_o),
    .buffer2_dac_cmp_o(b2_dac_o), .adc_channel_avail_o(avail_o)
  );

  rtc_analog_model u_rtc_analog_model
  (
    .buffer1_gain_i(b1_gain_o), .buffer2_gain_i(b2_gain_o), .buffer1_adc_ref_i(b1_ref_o),
    .buffer2_dac_cmp_i(b2_dac_o), .temp_sense_enable_i(ts_en_o),
    .temp_range_select_i(ts_rng_o), .buffer1_mv_o(b1_mv), .buffer2_mv_o(b2_mv),
    .sensor_mv_o(ts_mv)
  );

  // =====================================================================
  // Clock, reset and a free cycle count for settling measurements
  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) cyc <= cyc + 1;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic exp_err, output logic [31:0] rd);
    int n;
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    // Wait as long as the slave needs; only the watchdog ends a hang
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (pready_o !== 1'b1);
    rd = prdata_o;
    check("pready wait", 32'(n), 32'h1);
    check("pslverr", {31'h0, pslverr_o}, {31'h0, exp_err});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    apb(1'b1, a, {24'h0, d}, 4'hF, a != RTC_CTRL_ADDR, rd);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    apb(1'b0, a, 32'h0, 4'hF, a != RTC_CTRL_ADDR, rd);
    check("read data", rd, exp);
  endtask

  function automatic logic [2:0] onehot(input logic [1:0] c, input logic en);
    onehot = (en && c != 2'h0) ? 3'(1 << (c - 1)) : 3'h0;
  endfunction

  // Host-side factory pairs, plain defaults; one count per millivolt
  localparam int LOW_RANGE_GAIN_PARAM    = 256;
  localparam int LOW_RANGE_OFFSET_PARAM  = -950;
  localparam int HIGH_RANGE_GAIN_PARAM   = 256;
  localparam int HIGH_RANGE_OFFSET_PARAM = -1550;

  // Host temperature estimate in tenths folded to whole degrees
  function automatic int host_temp(input int measured_count, input logic rng);
    int gain;
    int offset;
    // pair picked by the range the host selected
    gain      = rng ? HIGH_RANGE_GAIN_PARAM : LOW_RANGE_GAIN_PARAM;
    offset    = rng ? HIGH_RANGE_OFFSET_PARAM : LOW_RANGE_OFFSET_PARAM;
    // count times gain over 256, plus offset, over 10
    host_temp = (measured_count * gain / 256 + offset) / 10;
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    bad_count++;
    give_verdict();
  end

  // =====================================================================
  // Test sequence
  initial
  begin
    logic [7:0] d;
    logic [7:0] d2;
    int         w;
    int         n;
    int         sum;
    logic [31:0] rdv;
    sys_rst_i = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h0;
    pwdata    = 32'h0;
    pstrb     = 4'h0;
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;

    // Reset state of the control register and the enable, ready, sensor enable, gain and channel outputs
    @(negedge clk_sys_i);
    check("outputs after reset", {en_o, rdy_o, ts_en_o, b1_gain_o, b2_gain_o, avail_o}, 0);
    rd_chk(RTC_CTRL_ADDR, {24'h0, RTC_CTRL_RESET});
    $display("test reset done");

    // Ready bit cannot be written, dropped strobe and unmapped place ignored
    wr(RTC_CTRL_ADDR, 8'h40);
    rd_chk(RTC_CTRL_ADDR, 32'h0);
    apb(1'b1, RTC_CTRL_ADDR, 32'hFF, 4'hE, 1'b0, rdv);
    check("write read data", rdv, 32'h0);
    rd_chk(RTC_CTRL_ADDR, 32'h0);
    wr(12'h210, 8'hFF);
    rd_chk(12'h210, 32'h0);
    rd_chk(RTC_CTRL_ADDR, 32'h0);
    $display("test access rules done");

    // Every gain code on both buffers, with and without the reference
    for (int i = 0; i < 8; i++)
    begin
      d = {i[2], 1'b0, i[1], i[0], i[1:0], ~i[1:0]};
      wr(RTC_CTRL_ADDR, d);
      @(negedge clk_sys_i);
      check("enable", {31'h0, en_o}, {31'h0, d[7]});
      check("sensor", {30'h0, ts_en_o, ts_rng_o}, {30'h0, d[5:4]});
      check("buffer1 gain", {29'h0, b1_gain_o}, {29'h0, onehot(d[1:0], d[7])});
      check("buffer2 gain", {29'h0, b2_gain_o}, {29'h0, onehot(d[3:2], d[7])});
      check("routes", {27'h0, b1_ref_o, b2_dac_o, avail_o},
            {27'h0, onehot(d[1:0], d[7]) != 0, onehot(d[3:2], d[7]) != 0,
             d[5], onehot(d[3:2], d[7]) != 0, onehot(d[1:0], d[7]) != 0});
      check("buffer1 level", {16'h0, b1_mv},
            {16'h0, (d[7] && d[1:0] != 0) ? 16'(1024 << (d[1:0] - 1)) : 16'h0});
      check("buffer2 level", {16'h0, b2_mv},
            {16'h0, (d[7] && d[3:2] != 0) ? 16'(1024 << (d[3:2] - 1)) : 16'h0});
      check("sensor level", {16'h0, ts_mv},
            {16'h0, d[5] ? (d[4] ? 16'd1800 : 16'd1200) : 16'h0});
      rd_chk(RTC_CTRL_ADDR, {24'h0, d});
    end
    $display("test gain codes done");

    // Settling: an interrupted enable restarts the count from the new rise
    wr(RTC_CTRL_ADDR, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      d2 = k[0] ? 8'h9B : 8'h80;
      wr(RTC_CTRL_ADDR, d2);
      w = cyc;
      if (k == 0)
      begin
        repeat (10) @(posedge clk_sys_i);
        wr(RTC_CTRL_ADDR, 8'h00);
        @(negedge clk_sys_i);
        check("ready after disable", {30'h0, en_o, rdy_o}, 32'h0);
        wr(RTC_CTRL_ADDR, 8'h80);
        w = cyc;
      end
      rd_chk(RTC_CTRL_ADDR, {24'h0, d2 | 8'h80});
      n = 0;
      while (rdy_o !== 1'b1 && n < 200)
      begin
        @(negedge clk_sys_i);
        n++;
      end
      check("settle cycles", 32'(cyc - w), 32'(SETTLE_CYCLES + 1));
      rd_chk(RTC_CTRL_ADDR, {24'h0, d2 | 8'hC0});
      wr(RTC_CTRL_ADDR, d2 | 8'h80);
      @(negedge clk_sys_i);
      check("ready held", {31'h0, rdy_o}, 32'h1);
      wr(RTC_CTRL_ADDR, 8'h00);
      @(negedge clk_sys_i);
      check("ready with enable off", {30'h0, en_o, rdy_o}, 32'h0);
    end
    $display("test settling done");

    // Host estimate in both ranges; a wrong range pair gives a wrong answer
    for (int r = 0; r < 2; r++)
    begin
      wr(RTC_CTRL_ADDR, r[0] ? 8'h30 : 8'h20);
      sum = 0;
      repeat (10)
      begin
        @(negedge clk_sys_i);
        sum += ts_mv;
      end
      check("temperature", 32'(host_temp(sum / 10, r[0])), 32'd25);
    end
    $display("test temperature done");
    give_verdict();
  end
endmodule
